// *** pslr_chk.sv ***
`default_nettype none
module pslr_chk
   import pslr_pkg::*;
#(
   parameter int slow_cycles = 20
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // device outputs
   input wire logic speed_led,
   input wire logic interrupt_out_n,
   input wire logic irq_pin_mode,
   input wire logic datapath_pwr_on,
   input wire logic datapath_reset,
   input wire logic tx_gate,
   input wire logic [1:0] mac_clk_sel,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ---------------------------------------------
   // window where the mac clock turns fast
   // ---------------------------------------------
   localparam int fast_lo = slow_cycles - 2;
   localparam int fast_hi = slow_cycles + 8;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_mac_slow: assert property ($rose(aresetn) |->
      (mac_clk_sel == mclk_slow)[*8]) else $error("mac clock not slow");
   a_mac_fast: assert property ($rose(aresetn) |->
      ##[fast_lo:fast_hi] mac_clk_sel == mclk_fast)
      else $error("mac clock not fast");
   a_spd_idle: assert property ((!datapath_pwr_on)[*3] |->
      speed_led == irq_pin_mode) else $error("speed led lit");
   a_tx_idle: assert property ((!datapath_pwr_on)[*3] |->
      !tx_gate) else $error("transmit while down");
   a_irq_mode: assert property (!interrupt_out_n |->
      irq_pin_mode) else $error("irq in data mode");
   a_rst_stretch: assert property ($rose(datapath_reset) |->
      datapath_reset[*7]) else $error("datapath reset short");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read answer late");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid) else $error("write answer dropped");
   // main scenarios reached
   c_pdn: cover property ($fell(datapath_pwr_on));
   c_irq: cover property ($fell(interrupt_out_n));
   c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind pslr_ctrl pslr_chk #(.slow_cycles(slow_cycles)) u_chk (
   .aclk, .aresetn, .speed_led, .interrupt_out_n, .irq_pin_mode,
   .datapath_pwr_on, .datapath_reset, .tx_gate, .mac_clk_sel,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// *** pslr_ctrl.sv ***
// Implementation choices: the register offsets and register access over AXI4-Lite.
`default_nettype none
module pslr_ctrl
   import pslr_pkg::*;
#(
   parameter int slow_cycles = slow_clk_cyc,
   parameter int blink_cycles = blink_cyc
) (
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // straps and line status from pins
   input wire logic regulator_off_strap,
   input wire logic irq_pin_select_strap,
   input wire logic por_done,
   input wire logic link_up_in,
   input wire logic carrier_in,
   input wire logic energy_in,
   // mac transmit side
   input wire logic tx_en_in,
   input wire logic tx_err_in,
   input wire logic transmit_data_bit_four,
   // outputs
   output logic link_activity_led,
   output logic speed_led,
   output logic regulator_enable,
   output logic interrupt_out_n,
   output logic irq_pin_mode,
   output logic datapath_pwr_on,
   output logic datapath_reset,
   output logic tx_gate,
   output logic [1:0] mac_clk_sel,
   // axi4-lite write address
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [6:0] sy1_q; // first stage, read only by second stage
   logic [6:0] sy2_q; // second stage
   wire [6:0] pins_w = {regulator_off_strap, irq_pin_select_strap,
                        por_done, link_up_in, carrier_in, energy_in,
                        tx_en_in | tx_err_in | transmit_data_bit_four};
   // two flops per pin, no reset: strap levels must pass a pin reset
   always_ff @(posedge aclk) begin
      if (clk_en) begin
         sy1_q <= pins_w;
         sy2_q <= sy1_q;
      end
   end
   wire s_reg_off = sy2_q[6];
   wire s_irq_sel = sy2_q[5];
   wire s_por = sy2_q[4];
   wire s_link = sy2_q[3];
   wire s_crs = sy2_q[2];
   wire s_energy = sy2_q[1];
   wire s_tx_any = sy2_q[0];

   // ----------------------------------------------------------------
   // strap capture
   // ----------------------------------------------------------------
   pslr_strap_type strap_q; // latched strap levels
   logic por_seen_q; // regulator strap sampled once per power-on
   logic rel_q; // first enabled cycle after reset release
   // irq select follows pin reset; regulator strap follows supplies only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rel_q <= 1'b0;
         strap_q.irq_sel <= 1'b1; // pull-up level
      end else if (clk_en) begin
         rel_q <= 1'b1;
         if (!rel_q)
            strap_q.irq_sel <= s_irq_sel;
      end
      if (clk_en && !s_por) begin
         por_seen_q <= 1'b0; // supplies not yet good
         strap_q.reg_off <= 1'b0; // pull-down level
      end else if (clk_en && !por_seen_q) begin
         por_seen_q <= 1'b1; // kept through pin reset
         strap_q.reg_off <= s_reg_off;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [4:0] ctrl_q; // control: pdn, iso, srst, aneg, speed
   logic [1:0] mode_q; // mode: energy power-down enable, energy irq mask
   logic eflag_q; // energy-present event, sticky
   logic [4:0] srst_cnt_q; // soft reset sequencer
   logic awrdy_q, wrdy_q, arrdy_q; // ready flops, low while held
   pslr_pwr_type pwr_q, pwr_d; // power state
   logic [3:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q, rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] bresp_q, rresp_q;
   wire wr_go = !awrdy_q && !wrdy_q && !bvalid_q;
   wire wr_ctrl = wr_go && awaddr_q == ctrl_off && wstrb_q[0];
   wire wr_mode = wr_go && awaddr_q == mode_off && wstrb_q[0];
   wire wr_stat = wr_go && awaddr_q == stat_off && wstrb_q[0];
   wire wr_ok = awaddr_q == ctrl_off || awaddr_q == mode_off
                || awaddr_q == stat_off;
   wire srst_busy = srst_cnt_q != 5'h00;
   wire srst_start = wr_ctrl && wdata_q[ctrl_srst_bit];
   wire rd_go = s_axi_arvalid && arrdy_q;
   wire [31:0] stat_w = {26'h0, eflag_q, s_energy, strap_q.irq_sel,
                         strap_q.reg_off, s_link, srst_busy};
   wire [31:0] rd_mux = (s_axi_araddr == ctrl_off) ? {27'h0, ctrl_q} :
                        (s_axi_araddr == mode_off) ? {30'h0, mode_q} :
                        (s_axi_araddr == stat_off) ? stat_w : 32'h0;
   wire rd_ok = s_axi_araddr == ctrl_off || s_axi_araddr == mode_off
                || s_axi_araddr == stat_off;
   wire ev_energy = s_energy && !eflag_q && pwr_q == pw_ed_down;

   // control: hard reset and soft reset load ctrl_rst; power-down does not
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= ctrl_rst; // isolate cleared
      end else if (clk_en) begin
         if (srst_cnt_q == 5'h01)
            ctrl_q <= ctrl_rst; // soft reset loads ctrl_rst, bit self-clears
         else if (wr_ctrl)
            ctrl_q <= wdata_q[4:0];
      end
   end
   // mode register survives soft reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q <= mode_rst;
      end else if (clk_en && wr_mode) begin
         mode_q <= wdata_q[1:0];
      end
   end
   // energy event: set wins over write-one clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         eflag_q <= 1'b0;
      end else if (clk_en) begin
         if (ev_energy)
            eflag_q <= 1'b1;
         else if (wr_stat && wdata_q[5])
            eflag_q <= 1'b0;
      end
   end
   // soft reset sequence, far inside the allowed time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         srst_cnt_q <= 5'h00;
      end else if (clk_en) begin
         if (srst_start && !srst_busy)
            srst_cnt_q <= 5'(srst_cyc);
         else if (srst_busy)
            srst_cnt_q <= srst_cnt_q - 5'h01;
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite slave
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awrdy_q <= 1'b1;
         wrdy_q <= 1'b1;
         awaddr_q <= 4'h0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'h0;
      end else if (clk_en) begin
         if (s_axi_awvalid && awrdy_q) begin
            awrdy_q <= 1'b0;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wrdy_q) begin
            wrdy_q <= 1'b0;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? 2'h0 : 2'h2;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
            awrdy_q <= 1'b1;
            wrdy_q <= 1'b1;
         end
      end
   end
   // read channel: one-cycle accept, answer next cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         arrdy_q <= 1'b1;
         rdata_q <= 32'h0;
         rresp_q <= 2'h0;
      end else if (clk_en) begin
         if (rd_go) begin
            rvalid_q <= 1'b1;
            arrdy_q <= 1'b0;
            rdata_q <= rd_mux;
            rresp_q <= rd_ok ? 2'h0 : 2'h2;
         end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
            arrdy_q <= 1'b1;
         end
      end
   end
   assign s_axi_awready = awrdy_q;
   assign s_axi_wready = wrdy_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arrdy_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // ----------------------------------------------------------------
   // power state machine
   // ----------------------------------------------------------------
   logic pdn_q; // power down bit last cycle
   logic [2:0] dp_rst_q; // datapath reset stretch
   wire pdn = ctrl_q[ctrl_pdn_bit];
   wire edpd = mode_q[mode_edpd_bit];
   always_comb begin
      pwr_d = pwr_q;
      case (pwr_q)
         pw_on: begin
            if (pdn)
               pwr_d = pw_gen_down;
            else if (edpd && !s_energy)
               pwr_d = pw_ed_down;
         end
         pw_gen_down: begin
            if (!pdn)
               pwr_d = pw_on;
         end
         pw_ed_down: begin
            if (pdn)
               pwr_d = pw_gen_down;
            else if (s_energy || !edpd)
               pwr_d = pw_on;
         end
         default: pwr_d = pw_on;
      endcase
   end
   // state register; registers are untouched by transitions
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_q <= pw_on;
         pdn_q <= 1'b0;
      end else if (clk_en) begin
         pwr_q <= pwr_d;
         pdn_q <= pdn;
      end
   end
   // datapath reset on leaving general power-down or soft reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dp_rst_q <= 3'h7;
      end else if (clk_en) begin
         if ((pdn_q && !pdn) || srst_busy)
            dp_rst_q <= 3'h7;
         else if (dp_rst_q != 3'h0)
            dp_rst_q <= dp_rst_q - 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // mac clock speed after reset
   // ----------------------------------------------------------------
   logic [$clog2(slow_cycles+1)-1:0] slow_cnt_q;
   wire slow_done = slow_cnt_q == ($bits(slow_cnt_q))'(slow_cycles);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slow_cnt_q <= '0;
      end else if (clk_en) begin
         if (srst_busy)
            slow_cnt_q <= '0;
         else if (!slow_done)
            slow_cnt_q <= slow_cnt_q + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // activity blink
   // ----------------------------------------------------------------
   logic [$clog2(blink_cycles+1)-1:0] blink_cnt_q;
   logic blink_q; // blink phase
   wire blink_end = blink_cnt_q == ($bits(blink_cnt_q))'(blink_cycles - 1);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         blink_cnt_q <= '0;
         blink_q <= 1'b0;
      end else if (clk_en) begin
         if (!s_crs) begin
            blink_cnt_q <= '0;
            blink_q <= 1'b0;
         end else if (blink_end) begin
            blink_cnt_q <= '0;
            blink_q <= !blink_q;
         end else begin
            blink_cnt_q <= blink_cnt_q + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // output flops
   // ----------------------------------------------------------------
   wire iso = ctrl_q[ctrl_iso_bit];
   wire up = pwr_q == pw_on;
   wire link_on = s_link && up && !(s_crs && blink_q);
   wire spd_on = ctrl_q[ctrl_spd_bit] && up && !iso;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link_activity_led <= 1'b0;
         speed_led <= 1'b0;
         regulator_enable <= 1'b1;
         interrupt_out_n <= 1'b1;
         irq_pin_mode <= 1'b1;
         datapath_pwr_on <= 1'b1;
         datapath_reset <= 1'b1;
         tx_gate <= 1'b0;
         mac_clk_sel <= mclk_slow;
      end else if (clk_en) begin
         link_activity_led <= link_on ^ strap_q.reg_off;
         speed_led <= spd_on ^ strap_q.irq_sel;
         regulator_enable <= !strap_q.reg_off;
         interrupt_out_n <= !(eflag_q && mode_q[mode_emask_bit]
                              && strap_q.irq_sel);
         irq_pin_mode <= strap_q.irq_sel;
         datapath_pwr_on <= up;
         datapath_reset <= dp_rst_q != 3'h0;
         tx_gate <= s_tx_any && up && !iso;
         mac_clk_sel <= (slow_done && ctrl_q[ctrl_aneg_bit])
                        ? mclk_fast : mclk_slow;
      end
   end
endmodule
`default_nettype wire

// *** pslr_mac_model.sv ***
`default_nettype none
module pslr_mac_model (
   // clock and scenario controls
   input wire logic aclk,
   input wire logic link_on,
   input wire logic carrier_on,
   input wire logic energy_on,
   input wire logic tx_on,
   // line and mac levels toward the device
   output logic link_up_in = 1'b0,
   output logic carrier_in = 1'b0,
   output logic energy_in = 1'b0,
   output logic tx_en_in = 1'b0,
   output logic tx_err_in = 1'b0,
   output logic transmit_data_bit_four = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] pat_q = 8'h5a; // wandering bit pattern
   // ---------------------------------------------
   // link, carrier, energy and tx enable follow the controls one edge later
   // ---------------------------------------------
   always @(posedge aclk) begin
      pat_q <= {pat_q[6:0], pat_q[7] ^ pat_q[5]};
      link_up_in <= link_on;
      energy_in <= energy_on;
      // frames keep coming, so a lost wake frame is simply resent
      carrier_in <= carrier_on;
      tx_en_in <= tx_on;
      // idle data lines wander instead of holding the last bit
      tx_err_in <= tx_on & pat_q[0];
      transmit_data_bit_four <= pat_q[1];
   end
endmodule
`default_nettype wire

// *** pslr_pkg.sv ***
`default_nettype none
package pslr_pkg;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] ctrl_off = 4'h0;
   localparam logic [3:0] mode_off = 4'h4;
   localparam logic [3:0] stat_off = 4'h8;
   // control register field positions
   localparam int ctrl_pdn_bit = 0;
   localparam int ctrl_iso_bit = 1;
   localparam int ctrl_srst_bit = 2;
   localparam int ctrl_aneg_bit = 3;
   localparam int ctrl_spd_bit = 4;
   // mode register field positions
   localparam int mode_edpd_bit = 0;
   localparam int mode_emask_bit = 1;
   // reset values
   localparam logic [4:0] ctrl_rst = 5'h08;
   localparam logic [1:0] mode_rst = 2'h0;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int clk_mhz = 125;
   localparam int slow_clk_ns = 16000;
   localparam int slow_clk_cyc = (slow_clk_ns * clk_mhz + 999) / 1000;
   localparam int blink_ms = 50;
   localparam int blink_cyc = blink_ms * 1000 * clk_mhz;
   localparam int srst_cyc = 16;
   // mac clock speed encodings
   localparam logic [1:0] mclk_slow = 2'h1;
   localparam logic [1:0] mclk_fast = 2'h2;
   // power state
   typedef enum logic [2:0] {
      pw_on = 3'b001,
      pw_gen_down = 3'b010,
      pw_ed_down = 3'b100
   } pslr_pwr_type;
   // strap group
   typedef struct packed {
      logic reg_off;
      logic irq_sel;
   } pslr_strap_type;
endpackage
`default_nettype wire

// *** tb.sv ***
`default_nettype none
module tb
   import pslr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, por_done, reg_strap, irq_strap, prev, seen;
   logic link_on, carrier_on, energy_on, tx_on;
   logic link_up_in, carrier_in, energy_in, tx_en_in, tx_err_in;
   logic transmit_data_bit_four, link_activity_led, speed_led;
   logic regulator_enable, interrupt_out_n, irq_pin_mode;
   logic datapath_pwr_on, datapath_reset, tx_gate;
   logic [1:0] mac_clk_sel, s_axi_bresp, s_axi_rresp, r;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, d, rnd;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   int fails = 0;
   int n_tests = 0;
   int n, cnt;
   pslr_ctrl #(.slow_cycles(20), .blink_cycles(4)) dut (
      .aclk, .aresetn, .clk_en(1'b1), .regulator_off_strap(reg_strap),
      .irq_pin_select_strap(irq_strap), .por_done, .link_up_in,
      .carrier_in, .energy_in, .tx_en_in, .tx_err_in,
      .transmit_data_bit_four, .link_activity_led, .speed_led,
      .regulator_enable, .interrupt_out_n, .irq_pin_mode,
      .datapath_pwr_on, .datapath_reset, .tx_gate, .mac_clk_sel,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   pslr_mac_model mac (
      .aclk, .link_on, .carrier_on, .energy_on, .tx_on, .link_up_in,
      .carrier_in, .energy_in, .tx_en_in, .tx_err_in,
      .transmit_data_bit_four);
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // ---------------------------------------------
   // expectation helpers
   // ---------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // pin level of an led: strap high means active low
   function automatic logic led_lvl(input logic strap, input logic on);
      return strap ^ on;
   endfunction
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic hang(input string nm);
      chk(nm, 1, 0);
      report_and_stop();
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge aclk);
   endtask
   // ---------------------------------------------
   // bus master cycles
   // ---------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [31:0] dat);
      int i;
      s_axi_awaddr <= a;
      s_axi_wdata <= dat;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
      if (i == 50) hang("write");
   endtask
   task automatic rd(input logic [3:0] a);
      int i;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
      if (i == 50) hang("read");
   endtask
   task automatic rdc(input string nm, input logic [3:0] a,
                      input logic [31:0] e);
      rd(a);
      chk(nm, e, d);
   endtask
   // reset with the clock running, straps held around release
   task automatic hw_reset;
      aresetn <= 1'b0;
      tick(4);
      por_done <= 1'b1;
      tick(8);
      aresetn <= 1'b1;
      tick(6);
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      {aresetn, por_done, link_on, carrier_on, energy_on, tx_on} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, prev, seen} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      rnd = xs(32'h7fa4);
      reg_strap = rnd[0];
      irq_strap = rnd[1];
      hw_reset();
      chk("regulator", !reg_strap, regulator_enable);
      chk("pin mode", irq_strap, irq_pin_mode);
      chk("mac clock", mclk_slow, mac_clk_sel);
      chk("link led", led_lvl(reg_strap, 0), link_activity_led);
      rdc("ctrl", ctrl_off, 32'h8);
      rdc("mode", mode_off, 32'h0);
      rdc("status", stat_off, {28'h0, irq_strap, reg_strap, 2'h0});
      rd(4'hc);
      chk("bad resp", 2'h2, r);
      chk("bad data", 0, d);
      wr(4'hc, 32'h0);
      chk("bad wresp", 2'h2, r);
      // link lit, then blinking with carrier
      link_on <= 1'b1;
      tick(6);
      chk("link led", led_lvl(reg_strap, 1), link_activity_led);
      carrier_on <= 1'b1;
      tick(4);
      cnt = 0;
      for (int i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (link_activity_led !== prev) cnt++;
         prev = link_activity_led;
      end
      chk("blinks", 1, cnt >= 4);
      carrier_on <= 1'b0;
      // speed led and isolation
      tx_on <= 1'b1;
      wr(ctrl_off, 32'h18);
      chk("wr resp", 2'h0, r);
      tick(4);
      chk("speed led", led_lvl(irq_strap, 1), speed_led);
      chk("tx gate", 1, tx_gate);
      wr(ctrl_off, 32'h1a);
      tick(4);
      chk("speed iso", led_lvl(irq_strap, 0), speed_led);
      chk("tx iso", 0, tx_gate);
      // general power-down and wake
      wr(ctrl_off, 32'h19);
      tick(4);
      chk("power", 0, datapath_pwr_on);
      rdc("ctrl kept", ctrl_off, 32'h19);
      wr(ctrl_off, 32'h18);
      for (int i = 0; i < 10; i++) begin
         @(posedge aclk);
         seen = seen | (datapath_reset === 1'b1);
      end
      chk("dp reset", 1, seen);
      chk("power up", 1, datapath_pwr_on);
      // energy power-down, random unused upper bits
      rnd = xs(rnd);
      wr(mode_off, {rnd[31:2], 2'h3});
      tick(6);
      chk("ed down", 0, datapath_pwr_on);
      chk("ed tx", 0, tx_gate);
      energy_on <= 1'b1;
      tick(6);
      chk("ed up", 1, datapath_pwr_on);
      chk("ed tx back", 1, tx_gate);
      chk("irq", !irq_strap, interrupt_out_n);
      rdc("ed stat", stat_off, {26'h0, 2'h3, irq_strap, reg_strap, 2'h2});
      wr(stat_off, 32'h20);
      rdc("ev clr", stat_off, {26'h0, 2'h1, irq_strap, reg_strap, 2'h2});
      rdc("ctrl kept", ctrl_off, 32'h18);
      wr(mode_off, 32'h2);
      energy_on <= 1'b0;
      tick(6);
      chk("ed off", 1, datapath_pwr_on);
      // soft reset keeps the surviving mode bits
      wr(ctrl_off, 32'h1c);
      for (n = 0; n < 40; n++) begin
         rd(stat_off);
         if (d[0] === 1'b0) break;
      end
      if (n == 40) hang("soft reset");
      chk("busy seen", 1, n > 0);
      rdc("ctrl srst", ctrl_off, 32'h8);
      rdc("mode srst", mode_off, 32'h2);
      // second hardware reset with both straps turned round
      reg_strap <= !reg_strap;
      irq_strap <= !irq_strap;
      hw_reset();
      chk("pin mode 2", irq_strap, irq_pin_mode);
      chk("regulator 2", reg_strap, regulator_enable);
      tick(30);
      chk("mac fast", mclk_fast, mac_clk_sel);
      report_and_stop();
   end
endmodule
`default_nettype wire
